// >>> core/tsmie_top.sv
// Transmit slot activity mask, condition flags and transmit interrupt
`timescale 1ns/1ps

module tsmie_top #(
    parameter int NSER = 4                  // Number of serializers
) (
    input  wire logic                    mclk,      // 20 MHz clock
    input  wire logic                    rst_b,     // Async reset, low
    input  wire tsmie_pkg::tsmie_req_t   req,       // Register request
    output logic [tsmie_pkg::DATA_W-1:0] rdData,    // Read data, next cycle
    input  wire logic                    txEnable,  // Transmitter running
    input  wire logic                    slotTick,  // End of a slot
    input  wire logic                    frameSync, // Frame start pulse
    input  wire tsmie_pkg::tsmie_evt_t   evt,       // Condition pulses
    input  wire logic [NSER-1:0]         serTxMode, // Serializer is tx
    output logic [NSER-1:0]              serShift,  // Shift enables
    output logic [tsmie_pkg::SLOT_W-1:0] slotNum,   // Current slot
    output logic                         txIrq      // Transmit interrupt
);

    // Refuse serializer counts the shift vector cannot hold
    if (NSER < 1 || NSER > 16) begin : g_chk
        $error("NSER must lie between 1 and 16");
    end

    ////////////////////////////////////////////////////////////////////
    // Reset release

    logic rstMeta_q;
    logic rstSync_b;

    // Assert at once, release after two edges to avoid metastability
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_b <= rstMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Mask bit governing a slot; 32 divides evenly, so low bits serve
    function automatic logic slotBit(
        input logic [tsmie_pkg::DATA_W-1:0] mask,
        input logic [tsmie_pkg::SLOT_W-1:0] slot
    );
        logic [tsmie_pkg::SLOT_SEL_W-1:0] sel;
        sel = slot[tsmie_pkg::SLOT_SEL_W-1:0];
        return mask[sel];
    endfunction

    // Decode one register offset against the request
    function automatic logic hit(
        input logic [tsmie_pkg::ADDR_W-1:0] addr,
        input logic [tsmie_pkg::ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers and decode

    logic [tsmie_pkg::DATA_W-1:0] mask_q;
    logic [tsmie_pkg::DATA_W-1:0] ien_q;
    logic [tsmie_pkg::DATA_W-1:0] status_q;
    logic [tsmie_pkg::DATA_W-1:0] status_d;
    logic [tsmie_pkg::SLOT_W-1:0] last_q;
    logic [tsmie_pkg::SLOT_W-1:0] slotCnt_q;
    logic [tsmie_pkg::DATA_W-1:0] rdData_q;
    logic [tsmie_pkg::DATA_W-1:0] setVec;
    logic [tsmie_pkg::DATA_W-1:0] clrVec;
    logic [tsmie_pkg::SLOT_W-1:0] wrLast;
    logic [NSER-1:0]              serShift_q;
    logic                         wrMask;
    logic                         wrIen;
    logic                         wrClr;
    logic                         wrFrm;
    logic                         slotActive;
    logic                         isLast;

    assign wrMask = req.wr && hit(req.addr, tsmie_pkg::MASK_OFS);
    assign wrIen  = req.wr && hit(req.addr, tsmie_pkg::IEN_OFS);
    assign wrClr  = req.wr && hit(req.addr, tsmie_pkg::CLR_OFS);
    assign wrFrm  = req.wr && hit(req.addr, tsmie_pkg::FRM_OFS);

    // Slot activity mask, all 32 bits writable
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            mask_q <= tsmie_pkg::MASK_RST;
        end else if (wrMask) begin
            mask_q <= req.wdata;
        end
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            ien_q <= tsmie_pkg::IEN_RST;
        end else if (wrIen) begin
            ien_q <= req.wdata & tsmie_pkg::IEN_MASK;
        end
    end

    // Frame length clamped, so a bad write cannot pass slot 383
    assign wrLast = (req.wdata[tsmie_pkg::FRM_LAST_LSB +: tsmie_pkg::SLOT_W]
                     > tsmie_pkg::LAST_MAX) ? tsmie_pkg::LAST_MAX
                  : req.wdata[tsmie_pkg::FRM_LAST_LSB +: tsmie_pkg::SLOT_W];

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            last_q <= tsmie_pkg::LAST_RST;
        end else if (wrFrm) begin
            last_q <= wrLast;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Slot counter

    assign isLast = (slotCnt_q == last_q);

    // counter wraps at the frame length
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            slotCnt_q <= '0;
        end else if (!txEnable || frameSync) begin
            slotCnt_q <= '0;
        end else if (wrFrm && wrLast <= slotCnt_q) begin
            // A shortened frame would strand the count past its end
            slotCnt_q <= '0;
        end else if (slotTick) begin
            slotCnt_q <= isLast ? '0 : slotCnt_q + 9'h001;
        end
    end

    assign slotNum = slotCnt_q;

    ////////////////////////////////////////////////////////////////////
    // Serializer shift enables

    assign slotActive = txEnable && slotBit(mask_q, slotCnt_q);

    // gate transmitters by slot activity
    // Registered, so shifting follows the slot counter by one cycle
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            serShift_q <= '0;
        end else begin
            serShift_q <= slotActive ? serTxMode : '0;
        end
    end

    assign serShift = serShift_q;

    ////////////////////////////////////////////////////////////////////
    // Condition flags

    // Last slot rides along with data ready, as the serializer reloads
    always_comb begin
        setVec = '0;
        setVec[tsmie_pkg::BIT_FRMSTART] = frameSync && txEnable;
        setVec[tsmie_pkg::BIT_DATARDY]  = evt.dataReady;
        setVec[tsmie_pkg::BIT_LAST]     = evt.dataReady && isLast;
        setVec[tsmie_pkg::BIT_DMAERR]   = evt.dmaErr;
        setVec[tsmie_pkg::BIT_CLKFAIL]  = evt.clkFail;
        setVec[tsmie_pkg::BIT_SYNCERR]  = evt.syncErr;
        setVec[tsmie_pkg::BIT_UNDERRUN] = evt.underrun;
    end

    assign clrVec = wrClr ? (req.wdata & tsmie_pkg::IEN_MASK) : '0;

    // set applied after clear so it wins
    assign status_d = (status_q & ~clrVec) | setVec;

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            status_q <= tsmie_pkg::STAT_RST;
        end else begin
            status_q <= status_d;
        end
    end

    assign txIrq = |(status_q & ien_q);

    ////////////////////////////////////////////////////////////////////
    // Read path

    // Data stand only in the cycle after the strobe; others read zero
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            rdData_q <= '0;
        end else if (!req.rd) begin
            rdData_q <= '0;
        end else begin
            case (req.addr)
                tsmie_pkg::MASK_OFS: rdData_q <= mask_q;
                tsmie_pkg::IEN_OFS:  rdData_q <= ien_q & tsmie_pkg::IEN_MASK;
                tsmie_pkg::STAT_OFS: rdData_q <= status_q;
                tsmie_pkg::FRM_OFS: begin
                    rdData_q <= '0;
                    rdData_q[tsmie_pkg::FRM_LAST_LSB +: tsmie_pkg::SLOT_W]
                        <= last_q;
                    rdData_q[tsmie_pkg::FRM_CNT_LSB +: tsmie_pkg::SLOT_W]
                        <= slotCnt_q;
                end
                default:             rdData_q <= '0;
            endcase
        end
    end

    assign rdData = rdData_q;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstSync_b);

    a_slot_bound: assert property (
        slotCnt_q < 9'd384 && slotCnt_q <= last_q
    ) else $error("slot counter out of range");

    a_slot_step: assert property (
        txEnable && slotTick && !frameSync && !isLast && !wrFrm
        |=> slotCnt_q == $past(slotCnt_q) + 9'd1
    ) else $error("slot counter did not advance");

    // high slots reuse low mask bits
    a_mask_modulo: assert property (
        txEnable && slotCnt_q >= 9'd32
        |-> slotActive == slotBit(mask_q, slotCnt_q - 9'd32)
    ) else $error("slot mask not applied modulo 32");

    a_slot_idle: assert property (
        !slotBit(mask_q, slotCnt_q) |=> serShift == '0
    ) else $error("shift in inactive slot");

    a_slot_shift: assert property (
        txEnable && slotBit(mask_q, slotCnt_q)
        |=> serShift == $past(serTxMode)
    ) else $error("active slot did not shift");

    a_irq_raise: assert property (
        ien_q[tsmie_pkg::BIT_UNDERRUN] && evt.underrun && !wrIen
        |=> txIrq
    ) else $error("enabled underrun gave no interrupt");

    a_irq_quiet: assert property (
        (status_q & ien_q) == '0 |-> !txIrq
    ) else $error("interrupt without enabled flag");

    // enable write lands in its bits
    a_ien_write: assert property (
        wrIen |=> ien_q == ($past(req.wdata) & 32'h0000_00BF)
    ) else $error("enable write mismatch");

    a_ien_rsvd: assert property (
        ien_q[31:8] == 24'h00_0000 && !ien_q[6]
    ) else $error("reserved enable bit set");

    a_frame_flag: assert property (
        frameSync && txEnable |=> status_q[7] [*1]
    ) else $error("frame start flag not set");

    // last slot flag with data ready
    a_last_flag: assert property (
        evt.dataReady && isLast |=> status_q[4] && status_q[5]
    ) else $error("last slot flag not set");

    a_flag_clear: assert property (
        wrClr && req.wdata[0] && !evt.underrun |=> !status_q[0]
    ) else $error("flag not cleared");

    a_flag_keep: assert property (
        status_q[2] && !(wrClr && req.wdata[2]) |=> status_q[2]
    ) else $error("flag lost without clear");

    a_set_wins: assert property (
        wrClr && req.wdata[3] && evt.dmaErr |=> status_q[3]
    ) else $error("clear beat set");

    a_data_flag: assert property (
        evt.dataReady |=> status_q[tsmie_pkg::BIT_DATARDY]
    ) else $error("data ready flag not set");

    a_dma_flag: assert property (
        evt.dmaErr |=> status_q[tsmie_pkg::BIT_DMAERR]
    ) else $error("dma error flag not set");

    a_clk_flag: assert property (
        evt.clkFail |=> status_q[tsmie_pkg::BIT_CLKFAIL]
    ) else $error("clock failure flag not set");

    a_sync_flag: assert property (
        evt.syncErr |=> status_q[tsmie_pkg::BIT_SYNCERR]
    ) else $error("sync error flag not set");

    a_urun_flag: assert property (
        evt.underrun |=> status_q[tsmie_pkg::BIT_UNDERRUN]
    ) else $error("underrun flag not set");

    // conditions with a clear enable stay off the interrupt
    a_irq_masked: assert property (
        !wrIen && ((status_q | setVec) & ien_q) == '0 |=> !txIrq
    ) else $error("disabled condition raised interrupt");

    // only the seven conditions are ever held
    a_flag_rsvd: assert property (
        status_q[31:8] == 24'h00_0000 && !status_q[6]
    ) else $error("reserved status bit set");

    // mask readback in the answer cycle
    a_read_mask: assert property (
        req.rd && req.addr == tsmie_pkg::MASK_OFS
        |=> rdData == $past(mask_q)
    ) else $error("mask readback mismatch");

    a_read_ien: assert property (
        req.rd && req.addr == tsmie_pkg::IEN_OFS
        |=> rdData == ($past(ien_q) & tsmie_pkg::IEN_MASK)
    ) else $error("enable readback mismatch");

    a_read_clr: assert property (
        req.rd && req.addr == tsmie_pkg::CLR_OFS |=> rdData == '0
    ) else $error("clear register read nonzero");

    // frame end never beyond the last legal slot
    a_frm_clamp: assert property (
        wrFrm |=> last_q <= tsmie_pkg::LAST_MAX
    ) else $error("frame end not clamped");

    // counter parked while the transmitter is off
    a_idle_count: assert property (
        !txEnable |=> slotCnt_q == '0
    ) else $error("slot counter ran while disabled");

    // Read data only in the cycle after the strobe
    a_read_idle: assert property (
        !$past(req.rd) |-> rdData == '0
    ) else $error("read data outside answer cycle");

endmodule

// >>> common/tsmie_pkg.sv
// Constants and carrier types for the transmit slot mask and irq block
package tsmie_pkg;

    // Register bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] MASK_OFS = 8'hB8;
    localparam logic [ADDR_W-1:0] IEN_OFS  = 8'hBC;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'hC0;
    localparam logic [ADDR_W-1:0] CLR_OFS  = 8'hC4;
    localparam logic [ADDR_W-1:0] FRM_OFS  = 8'hC8;

    // Condition bit positions, shared by enable, status and clear
    localparam int BIT_UNDERRUN = 0;
    localparam int BIT_SYNCERR  = 1;
    localparam int BIT_CLKFAIL  = 2;
    localparam int BIT_DMAERR   = 3;
    localparam int BIT_LAST     = 4;
    localparam int BIT_DATARDY  = 5;
    localparam int BIT_FRMSTART = 7;

    // Writable bits of the enable layout; 31..8 and 6 stay zero
    localparam logic [DATA_W-1:0] IEN_MASK = 32'h0000_00BF;

    // Reset values
    localparam logic [DATA_W-1:0] MASK_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] IEN_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] STAT_RST = 32'h0000_0000;

    // Slot counter geometry
    localparam int SLOT_MAX   = 384;
    localparam int SLOT_W     = 9;
    localparam int SLOT_MOD   = 32;
    localparam int SLOT_SEL_W = 5;
    localparam logic [SLOT_W-1:0] LAST_RST = 9'h17F;
    localparam logic [SLOT_W-1:0] LAST_MAX = 9'h17F;

    // Frame register field positions
    localparam int FRM_LAST_LSB = 0;
    localparam int FRM_CNT_LSB  = 16;

    // Register bus request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tsmie_req_t;

    // Transmit condition pulses from the rest of the port
    typedef struct packed {
        logic dataReady;
        logic dmaErr;
        logic clkFail;
        logic syncErr;
        logic underrun;
    } tsmie_evt_t;

endpackage

// >>> tb/tsmie_codec_model.sv
// Far-side codec pacing model: slot ticks and a frame sync pulse
`timescale 1ns/1ps

module tsmie_codec_model #(
    parameter int SLOT_CYC = 4        // Clocks per slot
) (
    input  wire logic mclk,           // Port clock
    input  wire logic run,            // Link running
    output logic      slotTick,       // Last clock of a slot
    output logic      frameSync       // Frame start pulse
);
    int   cnt  = 0;
    logic runQ = 1'b0;

    // Sync once on start; ticks stay low while stopped, never left stale
    always @(posedge mclk) begin
        runQ <= run;
        frameSync <= run && !runQ;
        cnt <= (run && cnt < SLOT_CYC - 1) ? cnt + 1 : 0;
        slotTick <= run && runQ && cnt == SLOT_CYC - 2;
    end
endmodule

// >>> tb/tsmie_bench.sv
// Bench for the transmit slot mask and interrupt block
`timescale 1ns/1ps

module tsmie_bench;
    logic                  mclk = 1'b0;
    logic                  rst_b = 1'b0;
    tsmie_pkg::tsmie_req_t req = '0;
    tsmie_pkg::tsmie_evt_t evt = '0;
    logic                  txEnable = 1'b0;
    logic                  run = 1'b0;
    logic [3:0]            serTxMode = 4'b1011;
    logic [31:0]           rdData;
    logic [3:0]            serShift;
    logic [3:0]            expShift = '0;
    logic [8:0]            slotNum;
    logic [8:0]            maxSlot = '0;
    logic                  txIrq, slotTick, frameSync;
    logic                  shiftChk = 1'b0;
    logic [31:0]           mask = 32'h8000_0005;
    int                    mismatches = 0;
    int                    n_checks = 0;
    int                    cycles = 0;
    int                    sb[5] = '{0, 1, 2, 3, 5};

    always #25 mclk = ~mclk;

    tsmie_top i_tsmie_top (.mclk(mclk), .rst_b(rst_b), .req(req),
        .rdData(rdData), .txEnable(txEnable), .slotTick(slotTick),
        .frameSync(frameSync), .evt(evt), .serTxMode(serTxMode),
        .serShift(serShift), .slotNum(slotNum), .txIrq(txIrq));

    tsmie_codec_model i_tsmie_codec_model (.mclk(mclk), .run(run),
        .slotTick(slotTick), .frameSync(frameSync));

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One-cycle strobes, released at the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        chk("rdData", e, rdData);
    endtask

    task automatic pulse(input logic [4:0] v);
        @(posedge mclk);
        evt <= v;
        @(posedge mclk);
        evt <= '0;
        #1;
    endtask

    task automatic waitSlot(input logic [8:0] v);
        int k;
        k = 0;
        while (slotNum !== v && k < 2000) begin
            @(negedge mclk);
            k++;
        end
        chk("slotNum", 32'(v), 32'(slotNum));
    endtask

    // Reference shift: one clock behind the slot that selects it
    always @(posedge mclk) begin
        cycles++;
        expShift <= (txEnable && mask[slotNum[4:0]]) ? serTxMode : '0;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    always @(negedge mclk) begin
        if (slotNum > maxSlot) maxSlot = slotNum;
        if (shiftChk) chk("serShift", 32'(expShift), 32'(serShift));
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(8'hB8, 32'h0000_0000);
        rd(8'hBC, 32'h0000_0000);
        rd(8'hC8, 32'h0000_017F);
        rd(8'h10, 32'h0000_0000);
        // Frame end beyond slot 383 is clamped back to it
        wr(8'hC8, 32'h0000_01FF);
        rd(8'hC8, 32'h0000_017F);
        // Reserved enable bits, written here only to prove they are dropped
        wr(8'hBC, 32'hFFFF_FFFF);
        rd(8'hBC, 32'h0000_00BF);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0000_0000);
        wr(8'hB8, mask);
        rd(8'hB8, mask);
        // Each of the five evt conditions: masked, then enabled, then cleared
        for (int i = 0; i < 5; i++) begin
            wr(8'hBC, 32'h0);
            pulse(5'(1 << i));
            chk("txIrq", 0, 32'(txIrq));
            rd(8'hC0, 32'(1 << sb[i]));
            wr(8'hBC, 32'(1 << sb[i]));
            #1;
            chk("txIrq", 1, 32'(txIrq));
            wr(8'hC4, 32'h0);
            chk("txIrq", 1, 32'(txIrq));
            wr(8'hC4, 32'(1 << sb[i]));
            #1;
            chk("txIrq", 0, 32'(txIrq));
        end
        // Underrun set lands on the same edge as its clear
        wr(8'hBC, 32'h0000_0001);
        pulse(5'b00001);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: 8'hC4, wdata: 32'h1};
        evt <= 5'b00001;
        @(posedge mclk);
        req.wr <= 1'b0;
        evt <= '0;
        #1;
        chk("txIrq", 1, 32'(txIrq));
        rd(8'hC0, 32'h0000_0001);
        wr(8'hC4, 32'h0000_00FF);
        // Reserved enable bits stay at zero from here on
        wr(8'hBC, 32'h0000_0090);
        // Full 384-slot frame with the mask repeating every 32 slots
        @(posedge mclk);
        txEnable <= 1'b1;
        run <= 1'b1;
        repeat (8) @(posedge mclk);
        shiftChk = 1'b1;
        waitSlot(9'd383);
        pulse(5'b10000);
        waitSlot(9'd0);
        chk("maxSlot", 32'd383, 32'(maxSlot));
        chk("txIrq", 1, 32'(txIrq));
        shiftChk = 1'b0;
        @(posedge mclk);
        txEnable <= 1'b0;
        run <= 1'b0;
        rd(8'hC0, 32'h0000_00B0);
        wr(8'hC4, 32'h0000_00FF);
        rd(8'hC0, 32'h0000_0000);
        chk("txIrq", 0, 32'(txIrq));
        results();
    end
endmodule
